/* File: hw/mstv_defs.svh */
// constants for the machine status and trap vector register bank
// Overview of operation
// - status fields two bits: Off, Initial, Clean, Dirty
// - extension summary is highest extension status
// - read-only instruction traps when Off, else unchanged
// - modify traps when Off, else becomes Dirty
// - unconfigure traps when Off, else becomes Initial
// - disable always executes, status becomes Off
// - enable always executes, status becomes Initial
// - dirty summary bit set when any field Dirty
// - one shared status copy for machine and supervisor
// - landing pad field one bit, one means awaited
// - trap vector register always exists, full width
// - base keeps bits down to two, aligned targets
// - mode 0 direct, 1 vectored, others reserved
// - vectored interrupts go to base plus 4*cause
// - vectored mode may need stricter base alignment
`ifndef MSTV_DEFS_SVH
`define MSTV_DEFS_SVH
`define MSTV_REG_W          64
`define MSTV_NUM_EXT        4
`define MSTV_ADDR_W         4
`define MSTV_OFF_TVEC       4'h0
`define MSTV_OFF_STATUS     4'h1
`define MSTV_OFF_IRQ_STAT   4'h2
`define MSTV_OFF_IRQ_MASK   4'h3
`define MSTV_OFF_STATUS_WR  4'h4
`define MSTV_ST_FLT_LSB     0
`define MSTV_ST_VEC_LSB     2
`define MSTV_ST_SUM_LSB     4
`define MSTV_ST_SUP_LP      6
`define MSTV_ST_MACH_LP     7
`define MSTV_ST_EXT_LSB     8
`define MSTV_ST_DIRTY       63
`define MSTV_TVEC_RESET     64'h0000000000000000
`define MSTV_VEC_ALIGN_BITS 8
`define MSTV_IRQ_W          3
`define MSTV_IRQ_TRAP       0
`define MSTV_IRQ_DIRTY      1
`define MSTV_IRQ_OFFUNIT    2
`endif

/* File: hw/mstv_pkg.sv */
// types for the machine status and trap vector register bank
package mstv_pkg;
    typedef enum logic [1:0] {
        MSTV_OFF   = 2'h0,
        MSTV_INIT  = 2'h1,
        MSTV_CLEAN = 2'h2,
        MSTV_DIRTY = 2'h3
    } mstv_ctx_t;
    typedef enum logic [2:0] {
        MSTV_OP_NONE   = 3'h0,
        MSTV_OP_READ   = 3'h1,
        MSTV_OP_MODIFY = 3'h2,
        MSTV_OP_UNCFG  = 3'h3,
        MSTV_OP_DISABL = 3'h4,
        MSTV_OP_ENABLE = 3'h5
    } mstv_op_t;
    typedef enum logic [1:0] {
        MSTV_MODE_DIRECT = 2'h0,
        MSTV_MODE_VECTOR = 2'h1
    } mstv_mode_t;
endpackage

/* File: hw/mstv_ctx_step.sv */
// next-state and trap decision for one context status field
`timescale 1ns/1ps
`default_nettype none
module mstv_ctx_step (
    input  wire logic [1:0]    cur,
    input  wire logic [2:0]    op,
    output logic [1:0]         nxt,
    output logic               trap
);
    always_comb
    begin
        nxt  = cur;
        trap = 1'b0;
        unique case (mstv_pkg::mstv_op_t'(op))
            mstv_pkg::MSTV_OP_READ:
            begin
                trap = (cur == mstv_pkg::MSTV_OFF);
            end
            mstv_pkg::MSTV_OP_MODIFY:
            begin
                trap = (cur == mstv_pkg::MSTV_OFF);
                if (!trap)
                    nxt = mstv_pkg::MSTV_DIRTY;
            end
            mstv_pkg::MSTV_OP_UNCFG:
            begin
                trap = (cur == mstv_pkg::MSTV_OFF);
                if (!trap)
                    nxt = mstv_pkg::MSTV_INIT;
            end
            mstv_pkg::MSTV_OP_DISABL: nxt = mstv_pkg::MSTV_OFF;
            mstv_pkg::MSTV_OP_ENABLE: nxt = mstv_pkg::MSTV_INIT;
            default:
            begin
                nxt  = cur;
                trap = 1'b0;
            end
        endcase
    end
endmodule // mstv_ctx_step
`default_nettype wire

/* File: hw/mstv_csr_bank.sv */
// machine status context fields, landing pad bits and trap vector register
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mstv_defs.svh"
module mstv_csr_bank (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    // register port
    input  wire logic [`MSTV_ADDR_W-1:0]    regAddr,
    input  wire logic [`MSTV_REG_W-1:0]     regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic [`MSTV_REG_W-1:0]          regRdata_r,
    // instruction side: one unit op per cycle
    input  wire logic                       unitOpValid,
    input  wire logic [2:0]                 unitOp,
    input  wire logic [2:0]                 unitSel,
    output logic                            unitIllegal_r,
    output logic                            unitOpDone_r,
    // landing pad capture from trap logic
    input  wire logic                       lpUpdate,
    input  wire logic                       lpToSup,
    input  wire logic                       lpValue,
    // trap target request
    input  wire logic                       trapReq,
    input  wire logic                       trapIsIrq,
    input  wire logic [5:0]                 trapCause,
    output logic [`MSTV_REG_W-1:0]          trapTarget_r,
    output logic                            trapTargetValid_r,
    output logic                            irq_r
);
    localparam int NSLOT = 2 + `MSTV_NUM_EXT;

    // slot 0 float, slot 1 vector, slots 2.. individual extensions;
    // one copy serves machine and supervisor views alike
    logic [1:0]             ctx_r [NSLOT];
    logic [1:0]             ctxNxt [NSLOT];
    logic [NSLOT-1:0]       ctxTrap;
    logic [`MSTV_REG_W-1:2] tvecBase_r;
    logic [1:0]             tvecMode_r;
    logic                   supLp_r;
    logic                   machLp_r;
    logic [`MSTV_IRQ_W-1:0] irqStat_r;
    logic [`MSTV_IRQ_W-1:0] irqMask_r;
    logic [1:0]             extSummary;
    logic                   dirtySum;
    logic [`MSTV_REG_W-1:0] statusWord;
    logic [`MSTV_REG_W-1:0] tvecWord;
    logic                   opIllegal;
    logic                   dirtyRise;
    logic                   dirtySum_r;
    logic                   wrStatus;
    logic                   wrTvec;
    logic                   wrIrqStat;
    logic                   wrIrqMask;
    logic [`MSTV_IRQ_W-1:0] irqSet;
    logic [`MSTV_IRQ_W-1:0] irqStat_nxt;
    logic [`MSTV_IRQ_W-1:0] irqMask_nxt;

    function automatic logic [1:0] mstv_max2(input logic [1:0] a, input logic [1:0] b);
        mstv_max2 = (a > b) ? a : b;
    endfunction

    function automatic logic mstv_hit(input logic [`MSTV_ADDR_W-1:0] a, input logic [`MSTV_ADDR_W-1:0] off);
        mstv_hit = (a == off);
    endfunction

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++)
        begin : g_slot
            logic [2:0] slotOp;
            assign slotOp = (unitOpValid && unitSel == 3'(g)) ? unitOp : 3'h0;
            mstv_ctx_step u_step (
                .cur  (ctx_r[g]),
                .op   (slotOp),
                .nxt  (ctxNxt[g]),
                .trap (ctxTrap[g])
            );
        end
    endgenerate

    always_comb
    begin
        extSummary = 2'h0;
        for (int i = 2; i < NSLOT; i++)
            extSummary = mstv_max2(extSummary, ctx_r[i]);
    end

    assign dirtySum = (ctx_r[0] == mstv_pkg::MSTV_DIRTY) || (ctx_r[1] == mstv_pkg::MSTV_DIRTY)
                    || (extSummary == mstv_pkg::MSTV_DIRTY);
    assign opIllegal = |ctxTrap;

    // write decodes
    assign wrStatus  = regWr && mstv_hit(regAddr, `MSTV_OFF_STATUS_WR);
    assign wrTvec    = regWr && mstv_hit(regAddr, `MSTV_OFF_TVEC);
    assign wrIrqStat = regWr && mstv_hit(regAddr, `MSTV_OFF_IRQ_STAT);
    assign wrIrqMask = regWr && mstv_hit(regAddr, `MSTV_OFF_IRQ_MASK);

    always_comb
    begin
        statusWord = '0;
        statusWord[`MSTV_ST_FLT_LSB +: 2] = ctx_r[0];
        statusWord[`MSTV_ST_VEC_LSB +: 2] = ctx_r[1];
        statusWord[`MSTV_ST_SUM_LSB +: 2] = extSummary;
        statusWord[`MSTV_ST_SUP_LP]       = supLp_r;
        statusWord[`MSTV_ST_MACH_LP]      = machLp_r;
        for (int i = 2; i < NSLOT; i++)
            statusWord[`MSTV_ST_EXT_LSB + 2*(i-2) +: 2] = ctx_r[i];
        statusWord[`MSTV_ST_DIRTY] = dirtySum;
    end

    assign tvecWord = {tvecBase_r, tvecMode_r};

    // context fields: instruction ops, with a software write taking priority
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NSLOT; i++)
                ctx_r[i] <= 2'h0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NSLOT; i++)
            begin
                if (wrStatus)
                begin
                    if (i == 0)
                        ctx_r[i] <= regWdata[`MSTV_ST_FLT_LSB +: 2];
                    else if (i == 1)
                        ctx_r[i] <= regWdata[`MSTV_ST_VEC_LSB +: 2];
                    else
                        ctx_r[i] <= regWdata[`MSTV_ST_EXT_LSB + 2*(i-2) +: 2];
                end
                else
                    ctx_r[i] <= ctxNxt[i];
            end
        end
    end

    // landing pad fields
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            supLp_r  <= 1'b0;
            machLp_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (lpUpdate && lpToSup)
                supLp_r <= lpValue;
            else if (wrStatus)
                supLp_r <= regWdata[`MSTV_ST_SUP_LP];
            if (lpUpdate && !lpToSup)
                machLp_r <= lpValue;
            else if (wrStatus)
                machLp_r <= regWdata[`MSTV_ST_MACH_LP];
        end
    end

    // trap vector: base low bits forced clear on a write selecting vectored mode so the
    // target sum needs no carry into them
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tvecBase_r <= (`MSTV_REG_W-2)'(`MSTV_TVEC_RESET >> 2);
            tvecMode_r <= 2'h0;
        end
        else if (clk_en && wrTvec)
        begin
            if (regWdata[1:0] == mstv_pkg::MSTV_MODE_VECTOR)
            begin
                tvecMode_r <= regWdata[1:0];
                tvecBase_r <= {regWdata[`MSTV_REG_W-1:`MSTV_VEC_ALIGN_BITS],
                               (`MSTV_VEC_ALIGN_BITS-2)'(0)};
            end
            else if (regWdata[1:0] == mstv_pkg::MSTV_MODE_DIRECT)
            begin
                tvecMode_r <= regWdata[1:0];
                tvecBase_r <= regWdata[`MSTV_REG_W-1:2];
            end
            else
                tvecBase_r <= regWdata[`MSTV_REG_W-1:2];
        end
    end

    // trap target, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trapTarget_r      <= '0;
            trapTargetValid_r <= 1'b0;
        end
        else if (clk_en)
        begin
            trapTargetValid_r <= trapReq;
            if (trapReq)
            begin
                if (trapIsIrq && tvecMode_r == mstv_pkg::MSTV_MODE_VECTOR)
                    trapTarget_r <= {tvecBase_r, 2'h0} + {56'h0, trapCause, 2'h0};
                else
                    trapTarget_r <= {tvecBase_r, 2'h0};
            end
        end
    end

    // instruction answers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unitIllegal_r <= 1'b0;
            unitOpDone_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            unitOpDone_r  <= unitOpValid;
            unitIllegal_r <= unitOpValid && opIllegal;
        end
    end

    assign dirtyRise = dirtySum && !dirtySum_r;

    // event flags: set wins over a write-one clear in the same cycle
    always_comb
    begin
        irqSet                    = '0;
        irqSet[`MSTV_IRQ_TRAP]    = trapReq;
        irqSet[`MSTV_IRQ_DIRTY]   = dirtyRise;
        irqSet[`MSTV_IRQ_OFFUNIT] = unitOpValid && opIllegal;
        irqStat_nxt = irqStat_r;
        if (wrIrqStat)
            irqStat_nxt = irqStat_r & ~regWdata[`MSTV_IRQ_W-1:0];
        irqStat_nxt = irqStat_nxt | irqSet;
        irqMask_nxt = irqMask_r;
        if (wrIrqMask)
            irqMask_nxt = regWdata[`MSTV_IRQ_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irqStat_r <= '0;
        else if (clk_en)
            irqStat_r <= irqStat_nxt;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irqMask_r <= '0;
        else if (clk_en)
            irqMask_r <= irqMask_nxt;
    end

    // previous dirty summary, for the rising-edge event
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            dirtySum_r <= 1'b0;
        else if (clk_en)
            dirtySum_r <= dirtySum;
    end

    // uses the values the flags take at this edge so the level does not lag a cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_r <= 1'b0;
        else if (clk_en)
            irq_r <= |(irqStat_nxt & irqMask_nxt);
    end

    // read data one cycle after the strobe, zero for unmapped
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata_r <= '0;
        else if (clk_en)
        begin
            if (regRd)
            begin
                if (mstv_hit(regAddr, `MSTV_OFF_TVEC))
                    regRdata_r <= tvecWord;
                else if (mstv_hit(regAddr, `MSTV_OFF_STATUS) || mstv_hit(regAddr, `MSTV_OFF_STATUS_WR))
                    regRdata_r <= statusWord;
                else if (mstv_hit(regAddr, `MSTV_OFF_IRQ_STAT))
                    regRdata_r <= {{(`MSTV_REG_W-`MSTV_IRQ_W){1'b0}}, irqStat_r};
                else if (mstv_hit(regAddr, `MSTV_OFF_IRQ_MASK))
                    regRdata_r <= {{(`MSTV_REG_W-`MSTV_IRQ_W){1'b0}}, irqMask_r};
                else
                    regRdata_r <= '0;
            end
            else
                regRdata_r <= '0;
        end
    end
endmodule // mstv_csr_bank
`default_nettype wire

/* File: tb/mstv_checker.sv */
// assertion checker for the status and trap vector bank
`timescale 1ns/1ps
`default_nettype none
module mstv_checker (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic [3:0]  regAddr,
    input wire logic        regRd,
    input wire logic [63:0] regRdata_r,
    input wire logic        unitOpValid,
    input wire logic        unitIllegal_r,
    input wire logic        unitOpDone_r,
    input wire logic        trapReq,
    input wire logic [63:0] trapTarget_r,
    input wire logic        trapTargetValid_r
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence rd_of(logic [3:0] a);
        regRd && clk_en && regAddr == a;
    endsequence
    function automatic logic [1:0] hi(logic [1:0] a, logic [1:0] b);
        return a > b ? a : b;
    endfunction
    op_done_a: assert property (unitOpValid && clk_en |=> unitOpDone_r)
        else $error("unit op got no completion");
    illegal_cause_a: assert property (unitIllegal_r |-> unitOpDone_r && $past(unitOpValid))
        else $error("illegal flag without an op");
    read_idle_a: assert property (!regRd && clk_en |=> regRdata_r == 64'h0)
        else $error("read data outside its slot");
    dirty_sum_a: assert property (rd_of(4'h1) |=> regRdata_r[63] ==
        (&regRdata_r[1:0] || &regRdata_r[3:2] || &regRdata_r[5:4])) else $error("dirty summary wrong");
    ext_max_a: assert property (rd_of(4'h1) |=> regRdata_r[5:4] ==
        hi(hi(regRdata_r[9:8], regRdata_r[11:10]), hi(regRdata_r[13:12], regRdata_r[15:14])))
        else $error("extension summary wrong");
    mode_legal_a: assert property (rd_of(4'h0) |=> !regRdata_r[1])
        else $error("reserved mode held");
    vec_align_a: assert property (rd_of(4'h0) ##1 regRdata_r[0] |-> regRdata_r[7:2] == 6'h0)
        else $error("vectored base not aligned");
    target_slot_a: assert property (trapReq && clk_en |=> trapTargetValid_r)
        else $error("trap target late");
    target_align_a: assert property (trapTargetValid_r |-> trapTarget_r[1:0] == 2'h0)
        else $error("trap target not aligned");
endmodule // mstv_checker
bind mstv_csr_bank mstv_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .regAddr(regAddr),
    .regRd(regRd), .regRdata_r(regRdata_r), .unitOpValid(unitOpValid), .unitIllegal_r(unitIllegal_r),
    .unitOpDone_r(unitOpDone_r), .trapReq(trapReq), .trapTarget_r(trapTarget_r),
    .trapTargetValid_r(trapTargetValid_r));
`default_nettype wire

/* File: tb/mstv_hart_model.sv */
// hart model: unit ops, landing pad updates and trap requests
`timescale 1ns/1ps
`default_nettype none
module mstv_hart_model (
    input  wire logic  ref_clk,
    output logic       unitOpValid,
    output logic [2:0] unitOp,
    output logic [2:0] unitSel,
    output logic       lpUpdate,
    output logic       lpToSup,
    output logic       lpValue,
    output logic       trapReq,
    output logic       trapIsIrq,
    output logic [5:0] trapCause
);
    initial {unitOpValid, unitOp, unitSel, lpUpdate, lpToSup, lpValue, trapReq, trapIsIrq, trapCause} = '0;
    // released lines flip so a stale value is never mistaken for a request
    task automatic op(input logic [2:0] o, input logic [2:0] s);
        @(posedge ref_clk);
        {unitOpValid, unitOp, unitSel} <= {1'b1, o, s};
        @(posedge ref_clk);
        {unitOpValid, unitOp} <= {1'b0, ~o};
    endtask
    task automatic lp(input logic s, input logic v);
        @(posedge ref_clk);
        {lpUpdate, lpToSup, lpValue} <= {1'b1, s, v};
        @(posedge ref_clk);
        {lpUpdate, lpValue} <= {1'b0, ~v};
    endtask
    task automatic trap(input logic i, input logic [5:0] c);
        @(posedge ref_clk);
        {trapReq, trapIsIrq, trapCause} <= {1'b1, i, c};
        @(posedge ref_clk);
        {trapReq, trapCause} <= {1'b0, ~c};
    endtask
endmodule // mstv_hart_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the status and trap vector bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        ref_clk = 1'b0;
    logic        rst_n, clkEn, regWr, regRd, rdLate, lpS, lpM, unitOpValid, lpUpdate, lpToSup, lpValue;
    logic        trapReq, trapIsIrq, unitIllegal_r, unitOpDone_r, trapTargetValid_r, irq_r;
    logic [3:0]  regAddr;
    logic [63:0] regWdata, regRdata_r, trapTarget_r, tv;
    logic [2:0]  unitOp, unitSel;
    logic [5:0]  trapCause;
    logic [1:0]  b;
    logic [1:0]  ctx [6];
    logic [63:0] rq[$], tq[$], iq[$];
    int          fails = 0, samplesChecked = 0;
    always #20 ref_clk = ~ref_clk;
    mstv_csr_bank u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clkEn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .unitOpValid(unitOpValid), .unitOp(unitOp),
        .unitSel(unitSel), .unitIllegal_r(unitIllegal_r), .unitOpDone_r(unitOpDone_r), .lpUpdate(lpUpdate),
        .lpToSup(lpToSup), .lpValue(lpValue), .trapReq(trapReq), .trapIsIrq(trapIsIrq), .trapCause(trapCause),
        .trapTarget_r(trapTarget_r), .trapTargetValid_r(trapTargetValid_r), .irq_r(irq_r));
    mstv_hart_model u_hart (.ref_clk(ref_clk), .unitOpValid(unitOpValid), .unitOp(unitOp), .unitSel(unitSel),
        .lpUpdate(lpUpdate), .lpToSup(lpToSup), .lpValue(lpValue), .trapReq(trapReq), .trapIsIrq(trapIsIrq),
        .trapCause(trapCause));
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        samplesChecked++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge ref_clk) rdLate <= regRd && clkEn;
    always @(negedge ref_clk)
    begin
        if (rdLate) chk("rdata", regRdata_r, rq.pop_front());
        if (unitOpDone_r) chk("illegal", 64'(unitIllegal_r), iq.pop_front());
        if (trapTargetValid_r) chk("target", trapTarget_r, tq.pop_front());
    end
    task automatic wr(input logic [3:0] a, input logic [63:0] d);
        @(posedge ref_clk);
        {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        {regWr, regWdata} <= {1'b0, ~d};
    endtask
    task automatic rd(input logic [3:0] a, input logic [63:0] e);
        rq.push_back(e);
        @(posedge ref_clk);
        {regRd, regAddr} <= {1'b1, a};
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    function automatic logic [63:0] stw();
        logic [1:0] m;
        m = 2'h0;
        stw = 64'h0;
        for (int i = 0; i < 4; i++)
        begin
            stw[8 + 2 * i +: 2] = ctx[2 + i];
            if (ctx[2 + i] > m) m = ctx[2 + i];
        end
        stw[7:0] = {lpM, lpS, m, ctx[1], ctx[0]};
        stw[63] = ctx[0] == 2'h3 || ctx[1] == 2'h3 || m == 2'h3;
    endfunction
    task automatic unit(input logic [2:0] o, input logic [2:0] s);
        logic ill;
        ill = s < 3'h6 && o <= 3'h3 && ctx[s] == 2'h0;
        if (s < 3'h6 && !ill)
            case (o)
                3'h2: ctx[s] = 2'h3;
                3'h3, 3'h5: ctx[s] = 2'h1;
                3'h4: ctx[s] = 2'h0;
                default: ;
            endcase
        iq.push_back(64'(ill));
        u_hart.op(o, s);
    endtask
    task automatic tvec(input logic [1:0] m);
        logic [63:0] d;
        logic [5:0]  c;
        d = {$urandom, $urandom};
        d[1:0] = m;
        c = 6'($urandom);
        wr(4'h0, d);
        if (m == 2'h1) tv = {d[63:8], 8'h01};
        else if (m == 2'h0) tv = d;
        else tv = {d[63:2], tv[1:0]};
        rd(4'h0, tv);
        for (int i = 0; i < 2; i++)
        begin
            tq.push_back({tv[63:2], 2'h0} + (tv[1:0] == 2'h1 && i == 1 ? {56'h0, c, 2'h0} : 64'h0));
            u_hart.trap(i[0], c);
        end
    endtask
    task automatic irq_is(input logic e);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq", 64'(irq_r), 64'(e));
    endtask
    initial
    begin
        #400000;
        fails++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'hC2DC));
        {rst_n, clkEn, regWr, regRd, lpS, lpM, regAddr, regWdata, tv} = {6'b010000, 132'h0};
        ctx = '{default: 2'h0};
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(4'h1, 64'h0);
        rd(4'h0, 64'h0);
        for (int i = 0; i < 40; i++)
        begin
            unit(3'($urandom_range(5, 1)), 3'($urandom_range(7, 0)));
            b = 2'($urandom);
            if (b[1]) lpS = b[0]; else lpM = b[0];
            u_hart.lp(b[1], b[0]);
            rd(4'h1, stw());
        end
        wr(4'h4, 64'h8000_0000_0000_24F6);
        ctx = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
        {lpM, lpS} = 2'h3;
        rd(4'h1, stw());
        rd(4'h4, stw());
        for (int i = 0; i < 4; i++) tvec(2'(8'h78 >> (2 * i)));
        @(posedge ref_clk);
        {clkEn, regWr} <= 2'b01;
        @(posedge ref_clk);
        {clkEn, regWr} <= 2'b10;
        rd(4'h0, tv);
        rd(4'hF, 64'h0);
        wr(4'hF, {64{1'b1}});
        rd(4'h0, tv);
        wr(4'h2, {64{1'b1}});
        rd(4'h2, 64'h0);
        wr(4'h3, 64'h1);
        irq_is(1'b0);
        tq.push_back({tv[63:2], 2'h0});
        u_hart.trap(1'b0, 6'h0);
        irq_is(1'b1);
        wr(4'h3, 64'h0);
        irq_is(1'b0);
        wr(4'h3, 64'h1);
        irq_is(1'b1);
        wr(4'h2, 64'h1);
        irq_is(1'b0);
        repeat (4) @(posedge ref_clk);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
